// File: verif/host_model.sv
`timescale 1ns/1ps

module host_model (
    input wire logic clock_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic sel_low_o,
    output logic sel_high_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [7:0] bus_o
);
    logic drive_q = 1'b0;
    logic [7:0] data_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    initial begin
        sel_low_o = 1'b0;
        sel_high_o = 1'b0;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
    end

    // ----------------------------------------
    // Wire level, released bus flips
    // ----------------------------------------
    assign bus_o = dev_oe_i ? dev_data_i : (drive_q ? data_q : ~last_q);
    always @(posedge clock_i) last_q <= bus_o;

    // ----------------------------------------
    // One access, selects held around strobe
    // ----------------------------------------
    task automatic access(input logic rd, input logic [1:0] loc, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge clock_i);
        sel_low_o <= loc[0];
        sel_high_o <= loc[1];
        drive_q <= !rd;
        data_q <= d;
        repeat (4) @(posedge clock_i);
        if (rd) rd_n_o <= 1'b0;
        else wr_n_o <= 1'b0;
        repeat (8) @(posedge clock_i);
        q = bus_o;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        repeat (8) @(posedge clock_i);
        drive_q <= 1'b0;
    endtask : access
endmodule : host_model

// File: verif/palette_checker_sva.sv
`timescale 1ns/1ps

module palette_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] pixel_index_in_i,
    input wire logic blank_n_i,
    input wire logic sync_n_i,
    input wire logic wide_mode_i,
    input wire logic reg_select_low_i,
    input wire logic reg_select_high_i,
    input wire logic host_wr_n_i,
    input wire logic host_rd_n_i,
    input wire logic [7:0] host_data_bus_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic host_data_bus_oe_o,
    input wire logic host_busy_o,
    input wire logic [7:0] red_o,
    input wire logic [7:0] green_o,
    input wire logic [7:0] blue_o,
    input wire logic sync_pedestal_o
);
    logic [2:0] live_q;
    logic [3:0] quiet_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) live_q <= 3'h0;
        else if (live_q != 3'h4) live_q <= live_q + 3'h1;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) quiet_q <= 4'h0;
        else if (!$stable({pixel_index_in_i, blank_n_i, sync_n_i, wide_mode_i})) quiet_q <= 4'h0;
        else if (!host_wr_n_i || !host_rd_n_i) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_blank_forces_zero: assert property (live_q == 3'h4 && !$past(blank_n_i, 4) |->
        {red_o, green_o, blue_o} == 24'h000000) else $error("blanked pixel not zero");
    a_pedestal_delay: assert property (live_q == 3'h4 |->
        sync_pedestal_o == $past(sync_n_i, 4)) else $error("pedestal not delayed sync");
    a_narrow_red: assert property ((!wide_mode_i)[*8] |->
        red_o[1:0] == red_o[7:6]) else $error("narrow red not expanded");
    a_narrow_green_blue: assert property ((!wide_mode_i)[*8] |->
        green_o[1:0] == green_o[7:6] && blue_o[1:0] == blue_o[7:6])
        else $error("narrow green or blue not expanded");
    a_bus_idle: assert property (host_rd_n_i[*8] |-> !host_data_bus_oe_o)
        else $error("data bus driven without read");
    a_bus_drive: assert property ($fell(host_rd_n_i) |-> ##[2:4] host_data_bus_oe_o)
        else $error("data bus not driven on read");
    a_busy_idle: assert property (host_wr_n_i[*8] |-> !host_busy_o)
        else $error("busy without writes");
    a_output_hold: assert property (quiet_q == 4'ha |->
        $stable({red_o, green_o, blue_o, sync_pedestal_o})) else $error("output moved");

    c_read: cover property ($fell(host_rd_n_i));
    c_blank: cover property (!blank_n_i);
    c_narrow: cover property ((!wide_mode_i)[*8]);
endmodule : palette_checker

bind colour_palette_lookup palette_checker palette_checker_inst (
    .clock_i(clock_i), .rst_i(rst_i), .pixel_index_in_i(pixel_index_in_i),
    .blank_n_i(blank_n_i), .sync_n_i(sync_n_i), .wide_mode_i(wide_mode_i),
    .reg_select_low_i(reg_select_low_i), .reg_select_high_i(reg_select_high_i),
    .host_wr_n_i(host_wr_n_i), .host_rd_n_i(host_rd_n_i), .host_data_bus_i(host_data_bus_i),
    .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
    .host_busy_o(host_busy_o), .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
    .sync_pedestal_o(sync_pedestal_o));

// File: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import palette_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] pix = 8'h00;
    logic blank_n = 1'b0;
    logic sync_n = 1'b1;
    logic wide = 1'b1;
    logic sel_low, sel_high, wr_n, rd_n, oe, busy, ped;
    logic [7:0] bus_in, bus_out, red, green, blue;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    initial forever #4 clock_i = ~clock_i;

    colour_palette_lookup colour_palette_lookup_inst (.clock_i(clock_i), .rst_i(rst_i),
        .pixel_index_in_i(pix), .blank_n_i(blank_n), .sync_n_i(sync_n), .wide_mode_i(wide),
        .reg_select_low_i(sel_low), .reg_select_high_i(sel_high), .host_wr_n_i(wr_n),
        .host_rd_n_i(rd_n), .host_data_bus_i(bus_in), .host_data_bus_o(bus_out),
        .host_data_bus_oe_o(oe), .host_busy_o(busy), .red_o(red), .green_o(green),
        .blue_o(blue), .sync_pedestal_o(ped));
    host_model host_model_inst (.clock_i(clock_i), .dev_data_i(bus_out), .dev_oe_i(oe),
        .sel_low_o(sel_low), .sel_high_o(sel_high), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .bus_o(bus_in));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            $display("unexpected at %0t: run too long", $time);
            close_out();
        end
    end

    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] loc, input logic [7:0] d);
        logic [7:0] q;
        host_model_inst.access(1'b0, loc, d, q);
    endtask : wr

    task automatic wr3(input logic [23:0] c);
        wr(LOC_COLOUR, c[23:16]);
        wr(LOC_COLOUR, c[15:8]);
        wr(LOC_COLOUR, c[7:0]);
    endtask : wr3

    task automatic rd_chk(input logic [1:0] loc, input logic [7:0] exp);
        logic [7:0] q;
        host_model_inst.access(1'b1, loc, 8'h00, q);
        chk({17'h0, q}, {17'h0, exp});
    endtask : rd_chk

    task automatic rd3(input logic [23:0] c);
        rd_chk(LOC_COLOUR, c[23:16]);
        rd_chk(LOC_COLOUR, c[15:8]);
        rd_chk(LOC_COLOUR, c[7:0]);
    endtask : rd3

    // Two pixels back to back, each {blank_n, sync_n, index}
    task automatic pix2(input logic [9:0] a, input logic [9:0] b, input logic [24:0] ea,
            input logic [24:0] eb);
        @(posedge clock_i);
        {blank_n, sync_n, pix} <= a;
        @(posedge clock_i);
        {blank_n, sync_n, pix} <= b;
        repeat (3) @(posedge clock_i);
        #1 chk({ped, red, green, blue}, ea);
        @(posedge clock_i);
        #1 chk({ped, red, green, blue}, eb);
    endtask : pix2

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_regs();
        rd_chk(LOC_MASK, 8'hff);
        rd_chk(LOC_WRITE_INDEX, 8'h00);
        rd_chk(LOC_READ_INDEX, 8'h00);
        chk({24'h000000, busy}, 25'h0000000);
    endtask : t_reset_regs

    task automatic t_table();
        wr(LOC_WRITE_INDEX, 8'h10);
        wr3(24'hc3a55a);
        wr3(24'h0f1e2d);
        rd_chk(LOC_WRITE_INDEX, 8'h12);
        wr(LOC_READ_INDEX, 8'h10);
        rd_chk(LOC_READ_INDEX, 8'h11);
        rd3(24'hc3a55a);
        rd3(24'h0f1e2d);
        rd_chk(LOC_WRITE_INDEX, 8'h13);
    endtask : t_table

    task automatic t_abort();
        wr(LOC_WRITE_INDEX, 8'h20);
        wr(LOC_COLOUR, 8'h11);
        wr(LOC_COLOUR, 8'h22);
        wr(LOC_WRITE_INDEX, 8'h20);
        wr3(24'h445566);
        wr(LOC_READ_INDEX, 8'h20);
        rd3(24'h445566);
    endtask : t_abort

    task automatic t_pixel();
        pix2(10'h310, 10'h311, {1'b1, 24'hc3a55a}, {1'b1, 24'h0f1e2d});
        pix2(10'h110, 10'h211, {1'b1, 24'h000000}, {1'b0, 24'h0f1e2d});
        wr(LOC_MASK, 8'h30);
        pix2(10'h31f, 10'h320, {1'b1, 24'hc3a55a}, {1'b1, 24'h445566});
        wr(LOC_READ_INDEX, 8'h11);
        rd3(24'h0f1e2d);
        wr(LOC_MASK, 8'hff);
    endtask : t_pixel

    task automatic t_narrow();
        @(posedge clock_i);
        wide <= 1'b0;
        wr(LOC_WRITE_INDEX, 8'h30);
        wr3(24'hea3f05);
        wr(LOC_READ_INDEX, 8'h30);
        rd3(24'h2a3f05);
        pix2(10'h330, 10'h330, {1'b1, 24'haaff14}, {1'b1, 24'haaff14});
        @(posedge clock_i);
        wide <= 1'b1;
    endtask : t_narrow

    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        t_reset_regs();
        t_table();
        t_abort();
        t_pixel();
        t_narrow();
        close_out();
    end
endmodule : tb_top

// File: verilog/colour_palette_lookup.sv
`timescale 1ns/1ps
`include "palette_consts.svh"

module colour_palette_lookup #(
    parameter int unsigned LUT_WORDS = `LUT_DEPTH,
    parameter int unsigned FIFO_WORDS = `FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] pixel_index_in_i,
    input wire logic blank_n_i,
    input wire logic sync_n_i,
    input wire logic wide_mode_i,
    input wire logic reg_select_low_i,
    input wire logic reg_select_high_i,
    input wire logic host_wr_n_i,
    input wire logic host_rd_n_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic host_busy_o,
    output logic [7:0] red_o,
    output logic [7:0] green_o,
    output logic [7:0] blue_o,
    output logic sync_pedestal_o
);
    import palette_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] clean_byte(input logic [7:0] d, input logic wide);
        clean_byte = wide ? d : {2'b00, d[`NARROW_BITS-1:0]};
    endfunction : clean_byte

    function automatic logic [7:0] to_dac(input logic [7:0] d, input logic wide);
        to_dac = wide ? d : {d[5:0], d[5:4]};
    endfunction : to_dac

    function automatic logic [7:0] pick_byte(input logic [23:0] w, input triple_pos_t p);
        unique case (p)
            POS_RED: pick_byte = w[`RED_LSB +: `COLOUR_BITS];
            POS_GREEN: pick_byte = w[`GREEN_LSB +: `COLOUR_BITS];
            POS_BLUE: pick_byte = w[`BLUE_LSB +: `COLOUR_BITS];
            default: pick_byte = 8'h00;
        endcase
    endfunction : pick_byte

    function automatic triple_pos_t next_pos(input triple_pos_t p);
        unique case (p)
            POS_RED: next_pos = POS_GREEN;
            POS_GREEN: next_pos = POS_BLUE;
            default: next_pos = POS_RED;
        endcase
    endfunction : next_pos

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [23:0] lut_mem [LUT_WORDS];
    logic wr_n_meta_q, wr_n_sync_q, wr_n_prev_q;
    logic rd_n_meta_q, rd_n_sync_q, rd_n_prev_q;
    logic [1:0] sel_meta_q, sel_sync_q;
    logic [7:0] data_meta_q, data_sync_q;
    logic wide_meta_q, wide_q;
    logic wr_start, rd_end;
    host_cmd_t push_cmd, cmd;
    logic fifo_in_ready, fifo_out_valid, pop;
    logic gap_q;
    logic [7:0] index_q, mask_q;
    logic [23:0] buffer_q;
    triple_pos_t wr_pos_q, rd_pos_q;
    logic do_wr_index, do_rd_index, do_colour_wr, do_colour_rd, do_mask;
    logic store_triple, load_buffer, host_xfer, index_touched;
    logic [7:0] host_addr, lut_addr;
    logic [23:0] lut_rdata, store_word;
    logic [7:0] p1_index_q;
    logic p1_blank_n_q, p1_sync_n_q;
    logic [23:0] p2_word_q;
    logic p2_blank_n_q, p2_sync_n_q;
    logic [7:0] p3_red_q, p3_green_q, p3_blue_q;
    logic p3_blank_n_q, p3_sync_n_q;

    // ----------------------------------------
    // Host pin and wide mode synchronisers
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_n_meta_q <= 1'b1;
            wr_n_sync_q <= 1'b1;
            wr_n_prev_q <= 1'b1;
            rd_n_meta_q <= 1'b1;
            rd_n_sync_q <= 1'b1;
            rd_n_prev_q <= 1'b1;
        end else begin
            wr_n_meta_q <= host_wr_n_i;
            wr_n_sync_q <= wr_n_meta_q;
            wr_n_prev_q <= wr_n_sync_q;
            rd_n_meta_q <= host_rd_n_i;
            rd_n_sync_q <= rd_n_meta_q;
            rd_n_prev_q <= rd_n_sync_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel_meta_q <= 2'h0;
            sel_sync_q <= 2'h0;
            data_meta_q <= 8'h00;
            data_sync_q <= 8'h00;
            wide_meta_q <= 1'b0;
            wide_q <= 1'b0;
        end else begin
            sel_meta_q <= {reg_select_high_i, reg_select_low_i};
            sel_sync_q <= sel_meta_q;
            data_meta_q <= host_data_bus_i;
            data_sync_q <= data_meta_q;
            wide_meta_q <= wide_mode_i;
            wide_q <= wide_meta_q;
        end
    end

    // Write taken at strobe start, read counted at strobe end
    assign wr_start = wr_n_prev_q & ~wr_n_sync_q;
    assign rd_end = ~rd_n_prev_q & rd_n_sync_q;
    assign push_cmd = '{is_read: rd_end, loc: host_loc_t'(sel_sync_q), data: data_sync_q};

    // ----------------------------------------
    // Command buffer
    // ----------------------------------------
    palette_fifo #(
        .WIDTH($bits(host_cmd_t)),
        .DEPTH(FIFO_WORDS)
    ) u_cmd_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(wr_start | rd_end),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_cmd),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(~gap_q),
        .out_data_o(cmd)
    );

    // One idle cycle after each table transfer
    assign pop = fifo_out_valid & ~gap_q;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= 1'b0;
            host_busy_o <= 1'b0;
        end else begin
            gap_q <= host_xfer;
            host_busy_o <= ~fifo_in_ready;
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    always_comb begin
        do_wr_index = pop & ~cmd.is_read & (cmd.loc == LOC_WRITE_INDEX);
        do_rd_index = pop & ~cmd.is_read & (cmd.loc == LOC_READ_INDEX);
        do_colour_wr = pop & ~cmd.is_read & (cmd.loc == LOC_COLOUR);
        do_mask = pop & ~cmd.is_read & (cmd.loc == LOC_MASK);
        do_colour_rd = pop & cmd.is_read & (cmd.loc == LOC_COLOUR);
    end

    assign store_triple = do_colour_wr & (wr_pos_q == POS_BLUE);
    assign load_buffer = do_rd_index | (do_colour_rd & (rd_pos_q == POS_BLUE));
    assign host_xfer = store_triple | load_buffer;
    assign index_touched = do_wr_index | do_rd_index;
    assign host_addr = do_rd_index ? cmd.data : index_q;
    assign store_word = {buffer_q[23:8], clean_byte(cmd.data, wide_q)};

    // ----------------------------------------
    // Index register
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            index_q <= `INDEX_RESET;
        end else if (do_wr_index) begin
            index_q <= cmd.data;
        end else if (do_rd_index) begin
            index_q <= cmd.data + 8'h01;
        end else if (host_xfer) begin
            index_q <= index_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Triple positions
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pos_q <= POS_RED;
            rd_pos_q <= POS_RED;
        end else if (index_touched) begin
            wr_pos_q <= POS_RED;
            rd_pos_q <= POS_RED;
        end else begin
            if (do_colour_wr) begin
                wr_pos_q <= next_pos(wr_pos_q);
            end
            if (do_colour_rd) begin
                rd_pos_q <= next_pos(rd_pos_q);
            end
        end
    end

    // ----------------------------------------
    // Colour buffer
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            buffer_q <= `BUFFER_RESET;
        end else if (load_buffer) begin
            buffer_q <= lut_rdata;
        end else if (do_colour_wr) begin
            unique case (wr_pos_q)
                POS_RED: buffer_q[`RED_LSB +: 8] <= clean_byte(cmd.data, wide_q);
                POS_GREEN: buffer_q[`GREEN_LSB +: 8] <= clean_byte(cmd.data, wide_q);
                POS_BLUE: buffer_q[`BLUE_LSB +: 8] <= clean_byte(cmd.data, wide_q);
                default: buffer_q <= buffer_q;
            endcase
        end
    end

    // ----------------------------------------
    // Pixel mask
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= `MASK_RESET;
        end else if (do_mask) begin
            mask_q <= cmd.data;
        end
    end

    // ----------------------------------------
    // Host read data
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            host_data_bus_o <= 8'h00;
            host_data_bus_oe_o <= 1'b0;
        end else begin
            host_data_bus_oe_o <= ~rd_n_sync_q;
            unique case (host_loc_t'(sel_sync_q))
                LOC_WRITE_INDEX: host_data_bus_o <= index_q;
                LOC_READ_INDEX: host_data_bus_o <= index_q;
                LOC_COLOUR: host_data_bus_o <= pick_byte(buffer_q, rd_pos_q);
                LOC_MASK: host_data_bus_o <= mask_q;
            endcase
        end
    end

    // ----------------------------------------
    // Colour table
    // ----------------------------------------
    // Host transfer takes the slot of one pixel
    assign lut_addr = host_xfer ? host_addr : p1_index_q;
    assign lut_rdata = lut_mem[lut_addr];

    always_ff @(posedge clock_i) begin
        if (store_triple) begin
            lut_mem[host_addr] <= store_word;
        end
    end

    // ----------------------------------------
    // Video pipeline
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            p1_index_q <= 8'h00;
            p1_blank_n_q <= 1'b0;
            p1_sync_n_q <= 1'b0;
        end else begin
            p1_index_q <= pixel_index_in_i & mask_q;
            p1_blank_n_q <= blank_n_i;
            p1_sync_n_q <= sync_n_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            p2_word_q <= 24'h000000;
            p2_blank_n_q <= 1'b0;
            p2_sync_n_q <= 1'b0;
        end else begin
            p2_word_q <= lut_rdata;
            p2_blank_n_q <= p1_blank_n_q;
            p2_sync_n_q <= p1_sync_n_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            p3_red_q <= 8'h00;
            p3_green_q <= 8'h00;
            p3_blue_q <= 8'h00;
            p3_blank_n_q <= 1'b0;
            p3_sync_n_q <= 1'b0;
        end else begin
            p3_red_q <= to_dac(p2_word_q[`RED_LSB +: 8], wide_q);
            p3_green_q <= to_dac(p2_word_q[`GREEN_LSB +: 8], wide_q);
            p3_blue_q <= to_dac(p2_word_q[`BLUE_LSB +: 8], wide_q);
            p3_blank_n_q <= p2_blank_n_q;
            p3_sync_n_q <= p2_sync_n_q;
        end
    end

    // ----------------------------------------
    // Converter inputs
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            red_o <= 8'h00;
            green_o <= 8'h00;
            blue_o <= 8'h00;
            sync_pedestal_o <= 1'b0;
        end else begin
            red_o <= p3_blank_n_q ? p3_red_q : 8'h00;
            green_o <= p3_blank_n_q ? p3_green_q : 8'h00;
            blue_o <= p3_blank_n_q ? p3_blue_q : 8'h00;
            sync_pedestal_o <= p3_sync_n_q;
        end
    end

endmodule : colour_palette_lookup

// File: verilog/palette_consts.svh
`ifndef PALETTE_CONSTS_SVH
`define PALETTE_CONSTS_SVH

// ----------------------------------------
// Host port locations
// ----------------------------------------
`define SEL_WRITE_INDEX 2'h0
`define SEL_COLOUR 2'h1
`define SEL_MASK 2'h2
`define SEL_READ_INDEX 2'h3

// ----------------------------------------
// Table geometry and colour fields
// ----------------------------------------
`define LUT_DEPTH 256
`define COLOUR_BITS 8
`define NARROW_BITS 6
`define RED_LSB 16
`define GREEN_LSB 8
`define BLUE_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MASK_RESET 8'hff
`define INDEX_RESET 8'h00
`define BUFFER_RESET 24'h000000

// ----------------------------------------
// Pipeline and buffering
// ----------------------------------------
`define PIPE_STAGES 3
`define FIFO_DEPTH 8

`endif

// File: verilog/palette_fifo.sv
`timescale 1ns/1ps

module palette_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_o = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // ----------------------------------------
    // Pointers and fill level
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

endmodule : palette_fifo

// File: verilog/palette_pkg.sv
package palette_pkg;

    typedef enum logic [1:0] {
        LOC_WRITE_INDEX = 2'b00,
        LOC_COLOUR = 2'b01,
        LOC_MASK = 2'b10,
        LOC_READ_INDEX = 2'b11
    } host_loc_t;

    typedef enum logic [1:0] {
        POS_RED = 2'b00,
        POS_GREEN = 2'b01,
        POS_BLUE = 2'b10
    } triple_pos_t;

    typedef struct packed {
        logic is_read;
        host_loc_t loc;
        logic [7:0] data;
    } host_cmd_t;

endpackage : palette_pkg
